// *** vsfm_core.sv ***
// Four output blocks, one packed-contact input block and an AXI4-Lite slave.
// Assumes contact and failure pins are asynchronous; one clock, sync reset.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "vsfm_map.svh"

// Functional notes
// - Zero setpoint closes, nonzero opens valve
// - Setpoint accepted only with good status
// - Uncertain or bad status de-energises drive
// - Channel select one to four binds block
// - Sensed contacts returned as position readback
// - Readback to process value, optional inversion
// - Backcalc carries process value or setpoint
// - Input select five links all channels
// - Contact A bit 2(n-1), B bit 2n-1
// - Packed byte to process value to output
// - Packed byte status normally reports good
// - Hardware failure reports bad device failure
// - Update after contacts stable filter time
// - Identifier is maker, type and serial
// - Contact high current reads as one
// - Unsensed channel returns setpoint as readback
module vsfm_core #(
	parameter int                  EXEC_CYCLES = `VSFM_EXEC_MS * `VSFM_CLK_MHZ * 1000,
	parameter int                  SEC_CYCLES  = `VSFM_CLK_MHZ * 1000000,
	parameter logic [23:0]         MFR_CODE    = 24'h00A5A5, // Arbitrary value
	parameter logic [15:0]         TYPE_CODE   = 16'h0A0A,   // Arbitrary value
	parameter logic [47:0]         SERIAL_NUM  = 48'h000000000001 // Arbitrary value
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [7:0]        end_position_contact,
	input  wire logic              hw_failure,
	output logic [3:0]             valve_drive,
	output vsfm_pkg::vsfm_byte_t   di_output_byte,
	output vsfm_pkg::vsfm_byte_t   di_status,
	output logic                   irq
);
	// Elaboration guard; the hold and drop checks need ticks at least two cycles apart
	if (EXEC_CYCLES < 2 || SEC_CYCLES < 2)
	begin
		$error("vsfm_core: divider counts must be at least 2");
	end

	// Pin synchronisers, first stage read only by the second
	logic [7:0] contact_m_q, contact_s_q;
	logic       hw_m_q, hw_s_q, hw_d1_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			contact_m_q <= 8'h00;
			contact_s_q <= 8'h00;
			hw_m_q      <= 1'b0;
			hw_s_q      <= 1'b0;
			hw_d1_q     <= 1'b0;
		end
		else
		begin
			contact_m_q <= end_position_contact;
			contact_s_q <= contact_m_q;
			hw_m_q      <= hw_failure;
			hw_s_q      <= hw_m_q;
			hw_d1_q     <= hw_s_q;
		end
	end

	// Execution and one-second enables from one clock
	logic [31:0] exec_cnt_q, sec_cnt_q;
	logic        exec_tick, sec_tick, tick_d1_q;
	assign exec_tick = (exec_cnt_q == 32'(EXEC_CYCLES - 1));
	assign sec_tick  = (sec_cnt_q == 32'(SEC_CYCLES - 1));
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			exec_cnt_q <= 32'h0;
			sec_cnt_q  <= 32'h0;
			tick_d1_q  <= 1'b0;
		end
		else
		begin
			exec_cnt_q <= exec_tick ? 32'h0 : exec_cnt_q + 32'h1;
			sec_cnt_q  <= sec_tick ? 32'h0 : sec_cnt_q + 32'h1;
			tick_d1_q  <= exec_tick;
		end
	end

	// Software-written block configuration
	vsfm_pkg::vsfm_word_t do_cfg_q [4];
	vsfm_pkg::vsfm_word_t di_cfg_q, irq_msk_q;
	logic [2:0]           irq_sts_q;
	logic                 wr_fire;
	logic [7:0]           aw_addr_q;
	vsfm_pkg::vsfm_word_t w_data_q;
	logic [3:0]           w_strb_q;
	logic                 aw_held_q, w_held_q, bvalid_q;
	logic [1:0]           bresp_q;

	function automatic vsfm_pkg::vsfm_word_t vsfm_merge(input vsfm_pkg::vsfm_word_t o,
		input vsfm_pkg::vsfm_word_t n, input logic [3:0] s);
		vsfm_pkg::vsfm_word_t r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction

	// Write channels may arrive in either order; each is held until paired
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `VSFM_RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h0;
			w_strb_q  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (aw_addr_q[7:2] <= `VSFM_OFS_ID_SER_HI >> 2) ? `VSFM_RESP_OKAY : `VSFM_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Register stores; read-only words silently ignore writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int b = 0; b < 4; b++)
				do_cfg_q[b] <= 32'h0;
			di_cfg_q  <= 32'h0;
			irq_msk_q <= 32'h0;
		end
		else if (wr_fire)
		begin
			if (aw_addr_q <= `VSFM_OFS_DO3)
				do_cfg_q[aw_addr_q[3:2]] <= vsfm_merge(do_cfg_q[aw_addr_q[3:2]], w_data_q, w_strb_q);
			if (aw_addr_q == `VSFM_OFS_DI_CFG)
				di_cfg_q <= vsfm_merge(di_cfg_q, w_data_q, w_strb_q);
			if (aw_addr_q == `VSFM_OFS_IRQ_MSK)
				irq_msk_q <= vsfm_merge(irq_msk_q, w_data_q, w_strb_q);
		end
	end

	// Channel binding: lowest numbered block wins a shared channel
	logic [3:0]           bound;
	logic [1:0]           owner [4];
	logic [3:0]           good;
	always_comb
	begin
		for (int c = 0; c < 4; c++)
		begin
			bound[c] = 1'b0;
			owner[c] = 2'h0;
			for (int b = 3; b >= 0; b--)
				if (do_cfg_q[b][`VSFM_SEL_LSB +: 3] == 3'(c + 1))
				begin
					bound[c] = 1'b1;
					owner[c] = 2'(b);
				end
			good[c] = do_cfg_q[owner[c]][`VSFM_QGOOD_BIT];
		end
	end

	// Accepted setpoints and valve drive, refreshed per execution
	vsfm_pkg::vsfm_byte_t acc_sp_q [4];
	logic [3:0]           drive_q;
	logic                 reject;
	assign reject      = |(bound & ~good) && exec_tick;
	assign valve_drive = drive_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			drive_q <= 4'h0;
			for (int c = 0; c < 4; c++)
				acc_sp_q[c] <= 8'h00;
		end
		else if (exec_tick)
		begin
			for (int c = 0; c < 4; c++)
			begin
				if (bound[c] && good[c])
				begin
					acc_sp_q[c] <= do_cfg_q[owner[c]][`VSFM_SP_LSB +: 8];
					drive_q[c]  <= |do_cfg_q[owner[c]][`VSFM_SP_LSB +: 8];
				end
				else
					drive_q[c] <= 1'b0;
			end
		end
	end

	// Per-block readback, process value and backcalc output
	vsfm_pkg::vsfm_byte_t rb_q [4], pv_q [4], bk_q [4];
	vsfm_pkg::vsfm_byte_t rb_d [4], pv_d [4];
	always_comb
	begin
		for (int b = 0; b < 4; b++)
		begin
			logic [1:0] ch;
			ch = 2'(do_cfg_q[b][`VSFM_SEL_LSB +: 3] - 3'h1);
			if (do_cfg_q[b][`VSFM_SENSE_BIT])
				rb_d[b] = {6'h00, contact_s_q[2*ch + 1], contact_s_q[2*ch]};
			else
				rb_d[b] = acc_sp_q[ch];
			if (do_cfg_q[b][`VSFM_INV_BIT])
				pv_d[b] = (rb_d[b] == 8'h00) ? 8'h01 : 8'h00;
			else
				pv_d[b] = rb_d[b];
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int b = 0; b < 4; b++)
			begin
				rb_q[b] <= 8'h00;
				pv_q[b] <= 8'h00;
				bk_q[b] <= 8'h00;
			end
		end
		else if (exec_tick)
		begin
			for (int b = 0; b < 4; b++)
			begin
				rb_q[b] <= rb_d[b];
				pv_q[b] <= pv_d[b];
				bk_q[b] <= do_cfg_q[b][`VSFM_BKPV_BIT] ? pv_d[b] : do_cfg_q[b][`VSFM_SP_LSB +: 8];
			end
		end
	end

	// Packed contact byte with stability filter in whole seconds
	vsfm_pkg::vsfm_byte_t field_q, dipv_q, field_d, st_q;
	logic [15:0]          stable_q, ftime;
	logic                 di_linked, pv_upd;
	assign ftime     = di_cfg_q[`VSFM_FTIME_LSB +: 16];
	assign di_linked = (di_cfg_q[2:0] == `VSFM_DI_SEL_ALL);
	assign field_d   = di_linked ? contact_s_q : 8'h00;
	assign pv_upd    = exec_tick && (ftime == 16'h0 || stable_q >= ftime) && (dipv_q != field_q);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			field_q  <= 8'h00;
			dipv_q   <= 8'h00;
			stable_q <= 16'h0;
		end
		else
		begin
			if (exec_tick)
				field_q <= field_d;
			if (exec_tick && field_d != field_q)
				stable_q <= 16'h0;
			else if (sec_tick && stable_q != 16'hFFFF)
				stable_q <= stable_q + 16'h1;
			if (pv_upd)
				dipv_q <= field_q;
		end
	end

	// Quality of the packed byte
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			st_q <= `VSFM_ST_GOOD;
		else
			st_q <= hw_s_q ? `VSFM_ST_BAD_DEVFAIL : `VSFM_ST_GOOD;
	end
	assign di_output_byte = dipv_q;
	assign di_status      = st_q;

	// Sticky events, write one to clear; a same-cycle set wins
	logic [2:0] ev, clr;
	assign ev  = {reject, hw_s_q && !hw_d1_q, pv_upd};
	assign clr = (wr_fire && aw_addr_q == `VSFM_OFS_IRQ_STS) ? (w_data_q[2:0] & {3{w_strb_q[0]}}) : 3'h0;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_sts_q <= 3'h0;
		else
			irq_sts_q <= (irq_sts_q & ~clr) | ev;
	end
	assign irq = |(irq_sts_q & irq_msk_q[2:0]);

	// Read path; readback words are packed snapshots of the block state
	logic                 rvalid_q;
	vsfm_pkg::vsfm_word_t rdata_q, rd_mux;
	logic [1:0]           rresp_q;
	logic [1:0]           ri;
	assign ri = s_axi_araddr[3:2];
	always_comb
	begin
		rd_mux = 32'h0;
		if (s_axi_araddr <= `VSFM_OFS_DO3)
			rd_mux = do_cfg_q[ri];
		else if (s_axi_araddr <= `VSFM_OFS_RB3)
			rd_mux = {8'h00, rb_q[ri], pv_q[ri], bk_q[ri]};
		else if (s_axi_araddr == `VSFM_OFS_DI_CFG)
			rd_mux = di_cfg_q;
		else if (s_axi_araddr == `VSFM_OFS_DI_STAT)
			rd_mux = {8'h00, field_q, st_q, dipv_q};
		else if (s_axi_araddr == `VSFM_OFS_IRQ_STS)
			rd_mux = {29'h0, irq_sts_q};
		else if (s_axi_araddr == `VSFM_OFS_IRQ_MSK)
			rd_mux = irq_msk_q;
		else if (s_axi_araddr == `VSFM_OFS_ID_MFR)
			rd_mux = {8'h00, MFR_CODE};
		else if (s_axi_araddr == `VSFM_OFS_ID_TYPE)
			rd_mux = {16'h0, TYPE_CODE};
		else if (s_axi_araddr == `VSFM_OFS_ID_SER_LO)
			rd_mux = SERIAL_NUM[31:0];
		else if (s_axi_araddr == `VSFM_OFS_ID_SER_HI)
			rd_mux = {16'h0, SERIAL_NUM[47:32]};
	end
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0;
			rresp_q  <= `VSFM_RESP_OKAY;
		end
		else if (s_axi_arvalid && !rvalid_q)
		begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_mux;
			rresp_q  <= (s_axi_araddr <= `VSFM_OFS_ID_SER_HI) ? `VSFM_RESP_OKAY : `VSFM_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_open_close;
		exec_tick && bound[0] && good[0] |=> valve_drive[0] == ($past(do_cfg_q[owner[0]][7:0]) != 8'h00);
	endproperty
	a_open_close: assert property (p_open_close) else $error("drive does not follow setpoint");
	property p_hold_setpoint;
		!exec_tick |=> $stable(acc_sp_q[0]) && $stable(valve_drive);
	endproperty
	a_hold_setpoint: assert property (p_hold_setpoint) else $error("setpoint changed off tick");
	property p_safe_drop;
		exec_tick && bound[1] && !good[1] |=> !valve_drive[1] ##1 !valve_drive[1] || $past(exec_tick);
	endproperty
	a_safe_drop: assert property (p_safe_drop) else $error("drive stays on with bad status");
	property p_invert;
		tick_d1_q && $past(do_cfg_q[0][`VSFM_INV_BIT]) |-> pv_q[0] == {7'h00, rb_q[0] == 8'h00};
	endproperty
	a_invert: assert property (p_invert) else $error("inverted process value wrong");
	property p_backcalc;
		tick_d1_q |-> bk_q[0] == ($past(do_cfg_q[0][`VSFM_BKPV_BIT]) ? pv_q[0] : $past(do_cfg_q[0][7:0]));
	endproperty
	a_backcalc: assert property (p_backcalc) else $error("backcalc output wrong");
	property p_pack;
		exec_tick && di_linked |=> field_q == $past(contact_s_q);
	endproperty
	a_pack: assert property (p_pack) else $error("packed byte wrong");
	property p_status;
		hw_s_q |=> di_status == `VSFM_ST_BAD_DEVFAIL ##1 1'b1;
	endproperty
	a_status: assert property (p_status) else $error("failure not reported");
	property p_good;
		!hw_s_q |=> di_status == `VSFM_ST_GOOD;
	endproperty
	a_good: assert property (p_good) else $error("status not good");
	property p_nofilter;
		exec_tick && ftime == 16'h0 |=> di_output_byte == $past(field_q);
	endproperty
	a_nofilter: assert property (p_nofilter) else $error("unfiltered update missed");
	property p_irq_set;
		$rose(hw_s_q) |-> ##[1:2] irq_sts_q[`VSFM_EV_HW_FAIL];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("failure event not latched");
	property p_cv_open;
		exec_tick && good[0] ##1 valve_drive[0];
	endproperty
	c_open: cover property (p_cv_open);
	property p_cv_pv;
		pv_upd && ftime != 16'h0;
	endproperty
	c_filtered: cover property (p_cv_pv);
	property p_cv_irq;
		irq ##1 !irq;
	endproperty
	c_irq: cover property (p_cv_irq);
endmodule

// *** vsfm_map.svh ***
// Register offsets, field positions, status codes and timing for the valve map.
// Assumes a 100 MHz aclk and byte addresses on a 32-bit AXI4-Lite port.
`ifndef VSFM_MAP_SVH
`define VSFM_MAP_SVH
`define VSFM_OFS_DO0        8'h00
`define VSFM_OFS_DO3        8'h0C
`define VSFM_OFS_RB0        8'h10
`define VSFM_OFS_RB3        8'h1C
`define VSFM_OFS_DI_CFG     8'h20
`define VSFM_OFS_DI_STAT    8'h24
`define VSFM_OFS_IRQ_STS    8'h28
`define VSFM_OFS_IRQ_MSK    8'h2C
`define VSFM_OFS_ID_MFR     8'h30
`define VSFM_OFS_ID_TYPE    8'h34
`define VSFM_OFS_ID_SER_LO  8'h38
`define VSFM_OFS_ID_SER_HI  8'h3C
`define VSFM_SP_LSB         0
`define VSFM_QGOOD_BIT      9
`define VSFM_SEL_LSB        10
`define VSFM_INV_BIT        13
`define VSFM_BKPV_BIT       14
`define VSFM_SENSE_BIT      15
`define VSFM_FTIME_LSB      16
`define VSFM_DI_SEL_ALL     3'h5
`define VSFM_ST_GOOD        8'h80
`define VSFM_ST_BAD_DEVFAIL 8'h0C
`define VSFM_EV_PV_UPD      0
`define VSFM_EV_HW_FAIL     1
`define VSFM_EV_SP_REJECT   2
`define VSFM_CLK_MHZ        100
`define VSFM_EXEC_MS        100
`define VSFM_RESP_OKAY      2'h0
`define VSFM_RESP_SLVERR    2'h2
`endif

// *** vsfm_pkg.sv ***
// Shared types of the valve setpoint and feedback map.
// Constants live in vsfm_map.svh.
package vsfm_pkg;
	typedef logic [7:0]  vsfm_byte_t;
	typedef logic [31:0] vsfm_word_t;
	typedef logic [2:0]  vsfm_sel_t;
endpackage

// *** vsfm_field_model.sv ***
// Field side of the valve map: four valves, each with two end-position contacts.
// Assumes the coupler clock; the bench may force the contact byte directly.
`timescale 1ns/1ps
module vsfm_field_model (
	input  wire logic       aclk,
	input  wire logic [3:0] valve_drive,
	input  wire logic       override_en,
	input  wire logic [7:0] override_byte,
	output logic [7:0]      end_position_contact
);
	// One cycle of valve travel; open actuates contact A, closed actuates B
	always_ff @(posedge aclk)
	begin
		for (int n = 0; n < 4; n++)
		begin
			end_position_contact[2*n]   <= override_en ? override_byte[2*n] : valve_drive[n];
			end_position_contact[2*n+1] <= override_en ? override_byte[2*n+1] : !valve_drive[n];
		end
	end
endmodule

// *** vsfm_core_tb.sv ***
// Self-checking bench for the valve map core, driving it over AXI4-Lite.
// Assumes shortened execution tick (8 cycles) and second (16 cycles).
`timescale 1ns/1ps
`include "vsfm_map.svh"
module vsfm_core_tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        hw_failure = 1'b0;
	logic        ovr_en = 1'b0;
	logic [7:0]  ovr_byte = 8'h00;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  rsp;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, d;
	logic [7:0]  contacts, out_byte, stat_byte;
	logic [3:0]  drive;
	logic [31:0] rb_cfg [6] = '{32'h8605, 32'hE605, 32'h6605, 32'h4605, 32'h6600, 32'hA605};
	logic [31:0] rb_exp [6] = '{32'h10105, 32'h10000, 32'h50000, 32'h50505, 32'h00101, 32'h10005};
	int          failures = 0;
	int          n_tests = 0;

	// 100 MHz clock
	always #5 aclk = ~aclk;

	vsfm_core #(.EXEC_CYCLES(8), .SEC_CYCLES(16), .MFR_CODE(24'h00C3C3), // Arbitrary codes
		.TYPE_CODE(16'h1234), .SERIAL_NUM(48'h00000000ABCD)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.end_position_contact(contacts), .hw_failure(hw_failure), .valve_drive(drive),
		.di_output_byte(out_byte), .di_status(stat_byte), .irq(irq));

	vsfm_field_model field (.aclk(aclk), .valve_drive(drive), .override_en(ovr_en),
		.override_byte(ovr_byte), .end_position_contact(contacts));

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Write address and data offered together, each released when taken
	// No wait limit here: only the watchdog ends a hung handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic awd;
		logic wd;
		logic done;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awd = 1'b0;
		wd = 1'b0;
		done = 1'b0;
		while (!done)
		begin
			@(posedge aclk);
			if (awd && wd && bvalid === 1'b1)
			begin
				bready <= 1'b0;
				chk("bresp", er, bresp);
				done = 1'b1;
			end
			if (!awd && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				awd = 1'b1;
			end
			if (!wd && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic done;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		done = 1'b0;
		while (!done)
		begin
			@(posedge aclk);
			if (rvalid === 1'b1)
			begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), e, d);
		chk("rresp", er, r);
	endtask

	// Execution ticks come every 8 cycles in this build
	task automatic ticks(input int n);
		repeat (n * 8) @(posedge aclk);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Hang guard, well beyond the thousand or so cycles the tests need
	initial
	begin
		repeat (30000) @(posedge aclk);
		failures++;
		results();
	end

	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk("status after reset", 8'h80, stat_byte);
		chk("drive after reset", 4'h0, drive);
		rd_chk(`VSFM_OFS_ID_MFR, 32'h00C3C3, `VSFM_RESP_OKAY);
		rd_chk(`VSFM_OFS_ID_TYPE, 32'h1234, `VSFM_RESP_OKAY);
		rd_chk(`VSFM_OFS_ID_SER_LO, 32'hABCD, `VSFM_RESP_OKAY);
		rd_chk(`VSFM_OFS_ID_SER_HI, 32'h0, `VSFM_RESP_OKAY);
		rd_chk(8'h40, 32'h0, `VSFM_RESP_SLVERR);
		wr(8'h40, 32'h1, `VSFM_RESP_SLVERR);
		wr(`VSFM_OFS_RB0, 32'hFFFF, `VSFM_RESP_OKAY);
		rd_chk(`VSFM_OFS_RB0, 32'h0, `VSFM_RESP_OKAY);
		// Zero closes, any other setpoint opens
		foreach (rb_exp[i])
		begin
			wr(`VSFM_OFS_DO0, 32'h0600 | ((i * 51) & 8'hFF), `VSFM_RESP_OKAY);
			ticks(3);
			chk("drive ch1", 4'(i != 0), drive);
		end
		// Channel select outside one to four leaves every valve off
		for (int ch = 0; ch < 6; ch++)
		begin
			wr(`VSFM_OFS_DO0, (ch << 10) | 32'h0201, `VSFM_RESP_OKAY);
			ticks(3);
			chk("drive by select", (ch >= 1 && ch <= 4) ? 4'h1 << (ch - 1) : 4'h0, drive);
		end
		// Status not good: valve released, rejection raised
		wr(`VSFM_OFS_IRQ_MSK, 32'h4, `VSFM_RESP_OKAY);
		wr(`VSFM_OFS_DO0 + 8'h04, 32'h0AFF, `VSFM_RESP_OKAY);
		ticks(3);
		chk("drive ch2", 4'h2, drive);
		wr(`VSFM_OFS_DO0 + 8'h04, 32'h08FF, `VSFM_RESP_OKAY);
		ticks(3);
		chk("drive bad status", 4'h0, drive);
		chk("irq reject", 1'b1, irq);
		wr(`VSFM_OFS_DO0, 32'h06FF, `VSFM_RESP_OKAY);
		wr(`VSFM_OFS_DO0 + 8'h04, 32'h0, `VSFM_RESP_OKAY);
		wr(`VSFM_OFS_IRQ_STS, 32'h4, `VSFM_RESP_OKAY);
		ticks(1);
		chk("irq cleared", 1'b0, irq);
		chk("drive good again", 4'h1, drive);
		// Readback, inversion and backcalc choices
		foreach (rb_cfg[i])
		begin
			wr(`VSFM_OFS_DO0, rb_cfg[i], `VSFM_RESP_OKAY);
			ticks(5);
			rd_chk(`VSFM_OFS_RB0, rb_exp[i], `VSFM_RESP_OKAY);
		end
		// Only channel 3 open: A3 set, B of the three closed valves set
		wr(`VSFM_OFS_DO0, 32'h0E01, `VSFM_RESP_OKAY);
		wr(`VSFM_OFS_DI_CFG, 32'h5, `VSFM_RESP_OKAY);
		ticks(5);
		rd_chk(`VSFM_OFS_DI_STAT, 32'h9A809A, `VSFM_RESP_OKAY);
		chk("input output", 8'h9A, out_byte);
		rd(`VSFM_OFS_IRQ_STS, d, rsp);
		chk("pv event", 1'b1, d[`VSFM_EV_PV_UPD]);
		chk("irq status rresp", `VSFM_RESP_OKAY, rsp);
		wr(`VSFM_OFS_DI_CFG, 32'h1, `VSFM_RESP_OKAY);
		ticks(5);
		chk("unlinked output", 8'h00, out_byte);
		// Chattering contacts under a one second filter never pass
		wr(`VSFM_OFS_DI_CFG, 32'h10005, `VSFM_RESP_OKAY);
		ovr_en <= 1'b1;
		for (int k = 0; k < 12; k++)
		begin
			ovr_byte <= k[0] ? 8'hF0 : 8'h0F;
			ticks(1);
		end
		chk("filtered chatter", 8'h00, out_byte);
		ovr_byte <= 8'h3C;
		ticks(8);
		chk("stable after filter", 8'h3C, out_byte);
		wr(`VSFM_OFS_DI_CFG, 32'h5, `VSFM_RESP_OKAY);
		ovr_byte <= 8'hC3;
		ticks(4);
		chk("no filter", 8'hC3, out_byte);
		// Hardware failure drives the bad status and its interrupt
		wr(`VSFM_OFS_IRQ_MSK, 32'h2, `VSFM_RESP_OKAY);
		hw_failure <= 1'b1;
		repeat (6) @(posedge aclk);
		chk("status failure", 8'h0C, stat_byte);
		chk("irq failure", 1'b1, irq);
		hw_failure <= 1'b0;
		// Clear without byte lane 0 must leave the event standing
		wstrb <= 4'hE;
		wr(`VSFM_OFS_IRQ_STS, 32'h2, `VSFM_RESP_OKAY);
		chk("irq kept by strobe", 1'b1, irq);
		wstrb <= 4'hF;
		wr(`VSFM_OFS_IRQ_STS, 32'h2, `VSFM_RESP_OKAY);
		repeat (6) @(posedge aclk);
		chk("status recovered", 8'h80, stat_byte);
		chk("irq failure cleared", 1'b0, irq);
		results();
	end
endmodule
